// *** hw/sarcu_top.sv ***
// Converter control unit: register file, sequencing, pin enables
`timescale 1ns/10ps
`default_nettype none
`include "sarcu_defines.svh"
module sarcu_top
	import sarcu_pkg::*;
#(
	parameter int CONV_TICKS = `SARCU_CONV_TICKS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register port
	input wire sarcu_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	// Port 1 function selects
	input wire logic [7:0] port1_function_select_a,
	input wire logic [7:0] port1_function_select_b,
	output logic [7:0] port1_gpio_mode,
	output logic [7:0] port1_analog_enable,
	// Converter core
	output sarcu_core_ctl_t core_ctl,
	input wire logic core_sample_done,
	input wire logic [9:0] core_sample,
	// Interrupt
	output logic converter_irq
);
	initial begin
		if (CONV_TICKS < 2 || CONV_TICKS > 1023) begin
			$error("CONV_TICKS out of range");
		end
	end

	typedef struct packed {
		sarcu_state_t state;
		logic [9:0] ticks;
		logic [7:0] converter_control_reg;
		logic [7:0] converter_clock_divider;
		logic [7:0] result_low_reg;
		logic [7:0] result_high_reg;
		logic [7:0] rdata;
		logic [9:0] sample;
		logic sample_ok;
		logic [2:0] done_sync;
	} sarcu_state_all_t;

	sarcu_state_all_t st_reg;
	sarcu_state_all_t st_next;
	logic ref_tick;
	logic wr_ctl;
	logic done_rise;
	logic conv_end;
	logic [2:0] chan;

	sarcu_refclk u_refclk (
		.clock(clock),
		.rstn(rstn),
		.prescale(st_reg.converter_clock_divider[`SARCU_PS_MSB:`SARCU_PS_LSB]),
		.gate(st_reg.converter_clock_divider[`SARCU_BIT_CLK_GATE]),
		.tick(ref_tick)
	);

	assign wr_ctl = sfr_req.wr && sfr_req.addr == `SARCU_ADDR_CONTROL;
	assign chan = st_reg.converter_control_reg[`SARCU_CHAN_MSB:`SARCU_CHAN_LSB];
	// Ends only once the tick count is spent and a fresh sample arrived
	assign conv_end = st_reg.state == SARCU_CONVERT && ref_tick
		&& st_reg.sample_ok
		&& st_reg.ticks == 10'(CONV_TICKS - 1);

	always_comb begin
		logic done_now;
		done_now = 1'b0;
		st_next = st_reg;
		st_next.done_sync = {st_reg.done_sync[1:0], core_sample_done};
		// Only a new rise of the synced done flag carries a fresh sample
		if (st_reg.done_sync[1] && !st_reg.done_sync[2]) begin
			st_next.sample = core_sample;
			st_next.sample_ok = 1'b1;
		end
		// Software writes; start kept only one cycle
		if (wr_ctl) begin
			st_next.converter_control_reg = sfr_req.wdata;
			// Flag is software-clear only, never software-set
			st_next.converter_control_reg[`SARCU_BIT_IRQ_FLAG] =
				st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG]
				& sfr_req.wdata[`SARCU_BIT_IRQ_FLAG]; // see [R6]
			st_next.converter_control_reg[`SARCU_BIT_DONE] =
				st_reg.converter_control_reg[`SARCU_BIT_DONE]
				& sfr_req.wdata[`SARCU_BIT_DONE]; // see [R4]
		end else begin
			st_next.converter_control_reg[`SARCU_BIT_START] = 1'b0; // see [R3]
		end
		if (sfr_req.wr && sfr_req.addr == `SARCU_ADDR_PRESCALE) begin
			st_next.converter_clock_divider = {4'h0, sfr_req.wdata[3:0]};
		end
		case (st_reg.state)
			SARCU_IDLE: begin
				if (st_reg.converter_control_reg[`SARCU_BIT_START]
					&& st_reg.converter_control_reg[`SARCU_BIT_POWER]) begin // see [R3] [R8]
					st_next.state = SARCU_CONVERT;
					st_next.ticks = 10'h000;
					st_next.sample_ok = 1'b0;
					st_next.converter_control_reg[`SARCU_BIT_DONE] = 1'b0; // see [R4]
				end
			end
			SARCU_CONVERT: begin
				st_next.converter_control_reg[`SARCU_BIT_DONE] = 1'b0; // see [R4]
				if (!st_reg.converter_control_reg[`SARCU_BIT_POWER]) begin
					st_next.state = SARCU_IDLE;
				end else if (conv_end) begin // see [R12]
					st_next.state = SARCU_IDLE;
					done_now = 1'b1;
				end else if (ref_tick
					&& st_reg.ticks != 10'(CONV_TICKS - 1)) begin
					st_next.ticks = st_reg.ticks + 10'h001;
				end
			end
			default: st_next.state = SARCU_IDLE;
		endcase
		if (done_now) begin
			// Result and done bit move together; set beats clear
			st_next.result_low_reg = st_reg.sample[7:0]; // see [R2] [R5] [R16]
			st_next.result_high_reg = {6'h00, st_reg.sample[9:8]}; // see [R2]
			st_next.converter_control_reg[`SARCU_BIT_DONE] = 1'b1; // see [R4] [R5]
		end
		if (done_now && !st_reg.converter_control_reg[`SARCU_BIT_DONE]) begin
			st_next.converter_control_reg[`SARCU_BIT_IRQ_FLAG] = 1'b1; // see [R6]
		end
		case (sfr_req.addr)
			`SARCU_ADDR_PRESCALE: st_next.rdata = st_reg.converter_clock_divider;
			`SARCU_ADDR_RES_LOW: st_next.rdata = st_reg.result_low_reg;
			`SARCU_ADDR_RES_HIGH: st_next.rdata = st_reg.result_high_reg;
			`SARCU_ADDR_CONTROL: st_next.rdata = st_reg.converter_control_reg;
			default: st_next.rdata = 8'h00;
		endcase
		if (!sfr_req.rd) begin
			st_next.rdata = st_reg.rdata;
		end
	end

	assign done_rise = !st_reg.converter_control_reg[`SARCU_BIT_DONE]
		&& st_next.converter_control_reg[`SARCU_BIT_DONE];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0; // see [R15]
		end else begin
			st_reg <= st_next;
		end
	end

	assign sfr_rdata = st_reg.rdata;
	assign converter_irq = st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG]
		& st_reg.converter_control_reg[`SARCU_BIT_IRQ_EN]; // see [R7]
	assign port1_gpio_mode = ~port1_function_select_a; // see [R13]
	assign port1_analog_enable = port1_function_select_a
		& port1_function_select_b; // see [R14]
	assign core_ctl.start = st_reg.state == SARCU_CONVERT
		&& st_reg.ticks == 10'h000;
	assign core_ctl.chan = chan; // see [R1]
	assign core_ctl.power = st_reg.converter_control_reg[`SARCU_BIT_POWER]; // see [R8]
	assign core_ctl.ref_clk = ref_tick; // see [R10]

	// Single clock domain for every property below
	default clocking sarcu_cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	// Start strobe and sequencing
	start_clears_a: assert property ( // see [R3]
		(wr_ctl && sfr_req.wdata[`SARCU_BIT_START]) ##1 !wr_ctl
		|=> !st_reg.converter_control_reg[`SARCU_BIT_START])
		else $error("start bit not cleared");

	start_one_cycle_a: assert property ( // see [R3]
		st_reg.converter_control_reg[`SARCU_BIT_START] && !wr_ctl
		|=> !st_reg.converter_control_reg[`SARCU_BIT_START])
		else $error("start bit held");

	start_begins_a: assert property ( // see [R3]
		st_reg.state == SARCU_IDLE
		&& st_reg.converter_control_reg[`SARCU_BIT_START]
		&& st_reg.converter_control_reg[`SARCU_BIT_POWER]
		|=> st_reg.state == SARCU_CONVERT && core_ctl.start)
		else $error("start did not begin conversion");

	start_needs_power_a: assert property ( // see [R8]
		st_reg.state == SARCU_IDLE
		&& !st_reg.converter_control_reg[`SARCU_BIT_POWER]
		|=> st_reg.state == SARCU_IDLE)
		else $error("converted while shut off");

	abort_on_power_a: assert property ( // see [R8]
		st_reg.state == SARCU_CONVERT
		&& !st_reg.converter_control_reg[`SARCU_BIT_POWER]
		|=> st_reg.state == SARCU_IDLE
		&& !st_reg.converter_control_reg[`SARCU_BIT_DONE])
		else $error("shut off did not abort");

	// Done bit, result registers, sample capture and tick count
	busy_done_low_a: assert property ( // see [R4]
		st_reg.state == SARCU_CONVERT && !conv_end
		|=> !st_reg.converter_control_reg[`SARCU_BIT_DONE])
		else $error("done high while busy");

	done_only_end_a: assert property ( // see [R4]
		!st_reg.converter_control_reg[`SARCU_BIT_DONE] && !conv_end
		|=> !st_reg.converter_control_reg[`SARCU_BIT_DONE])
		else $error("done set without completion");

	result_with_done_a: assert property ( // see [R2] [R5]
		conv_end && st_reg.converter_control_reg[`SARCU_BIT_POWER]
		|=> st_reg.converter_control_reg[`SARCU_BIT_DONE]
		&& st_reg.result_low_reg == $past(st_reg.sample[7:0])
		&& st_reg.result_high_reg == {6'h00, $past(st_reg.sample[9:8])})
		else $error("result not loaded with done");

	result_holds_a: assert property ( // see [R16]
		st_reg.state == SARCU_CONVERT && !conv_end
		|=> $stable(st_reg.result_low_reg) && $stable(st_reg.result_high_reg))
		else $error("result changed mid conversion");

	high_bits_zero_a: assert property ( // see [R2]
		st_reg.result_high_reg[7:2] == 6'h00)
		else $error("result high spare bits set");

	sample_capture_a: assert property ( // see [R5]
		st_reg.done_sync[1] && !st_reg.done_sync[2]
		|=> st_reg.sample == $past(core_sample) && st_reg.sample_ok)
		else $error("fresh sample not captured");

	ticks_bounded_a: assert property ( // see [R12]
		st_reg.ticks <= 10'(CONV_TICKS - 1))
		else $error("tick count overran");

	// Interrupt flag and request
	flag_on_rise_a: assert property ( // see [R6]
		done_rise |=> st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG])
		else $error("flag not set on done rise");

	flag_sticky_a: assert property ( // see [R6]
		st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG] && !wr_ctl
		|=> st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG])
		else $error("flag lost without write");

	flag_only_rise_a: assert property ( // see [R6]
		!st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG] && !done_rise
		|=> !st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG])
		else $error("flag set without done rise");

	irq_gate_a: assert property ( // see [R7]
		converter_irq == (st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG]
		&& st_reg.converter_control_reg[`SARCU_BIT_IRQ_EN]))
		else $error("irq mismatch");

	// Routing to the core, clock divider and gate, and pins
	chan_route_a: assert property ( // see [R1]
		core_ctl.chan == st_reg.converter_control_reg[4:2])
		else $error("channel not routed");

	power_route_a: assert property ( // see [R8]
		core_ctl.power == st_reg.converter_control_reg[`SARCU_BIT_POWER])
		else $error("power not routed");

	ref_gated_a: assert property ( // see [R10]
		!st_reg.converter_clock_divider[`SARCU_BIT_CLK_GATE] |=> !ref_tick)
		else $error("reference tick while gated");

	prescale_spare_a: assert property ( // see [R9]
		st_reg.converter_clock_divider[7:4] == 4'h0)
		else $error("prescale spare bits set");

	prescale_write_a: assert property ( // see [R9]
		sfr_req.wr && sfr_req.addr == `SARCU_ADDR_PRESCALE
		|=> st_reg.converter_clock_divider == {4'h0, $past(sfr_req.wdata[3:0])})
		else $error("prescale write lost");

	analog_path_a: assert property ( // see [R13] [R14]
		port1_analog_enable == (port1_function_select_a & port1_function_select_b)
		&& port1_gpio_mode == ~port1_function_select_a)
		else $error("pin select mismatch");

	// Main scenarios
	conv_cov: cover property (
		st_reg.state == SARCU_CONVERT ##[1:200] conv_end);

	irq_cov: cover property (
		$rose(converter_irq));

	clear_cov: cover property (
		st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG] ##1
		!st_reg.converter_control_reg[`SARCU_BIT_IRQ_FLAG]);

	abort_cov: cover property (
		st_reg.state == SARCU_CONVERT
		&& !st_reg.converter_control_reg[`SARCU_BIT_POWER]);

	gated_cov: cover property (
		st_reg.state == SARCU_CONVERT
		&& !st_reg.converter_clock_divider[`SARCU_BIT_CLK_GATE]);
endmodule : sarcu_top
`default_nettype wire

// *** hw/sarcu_defines.svh ***
// Offsets, field positions, reset values and timing counts of the converter
// Function
// [R1] Channel field bits 4:2 selects port pin
// [R2] Result split: low byte, bits 9:8 high
// [R3] Start bit begins conversion, self-clears next cycle
// [R4] Done bit low while converting, set finishing
// [R5] Result loaded together with done bit rising
// [R6] Irq flag set on done rising, software clears
// [R7] Irq request while flag and enable set
// [R8] Software enables, waits calibration, then starts
// [R9] Prescaler codes 0,1,2 divide by 1,2,4
// [R10] Divider bit 3 gates reference clock
// [R11] Software keeps reference clock 2 to 16 MHz
// [R12] Conversion about 4 us at 8 MHz
// [R13] Select-a zero means GPIO, one alternate
// [R14] Analog path needs select-a and select-b set
// [R15] All registers reset to zero
// [R16] Results hold until the conversion completes
`ifndef SARCU_DEFINES_SVH
`define SARCU_DEFINES_SVH
`define SARCU_ADDR_PRESCALE 8'h94
`define SARCU_ADDR_RES_LOW 8'h95
`define SARCU_ADDR_RES_HIGH 8'h96
`define SARCU_ADDR_CONTROL 8'h97
`define SARCU_RESET_VALUE 8'h00
`define SARCU_BIT_DONE 0
`define SARCU_BIT_START 1
`define SARCU_CHAN_LSB 2
`define SARCU_CHAN_MSB 4
`define SARCU_BIT_POWER 5
`define SARCU_BIT_IRQ_EN 6
`define SARCU_BIT_IRQ_FLAG 7
`define SARCU_PS_LSB 0
`define SARCU_PS_MSB 2
`define SARCU_BIT_CLK_GATE 3
`define SARCU_CONV_NS 4000
`define SARCU_REF_PERIOD_NS 125
`define SARCU_CONV_TICKS (`SARCU_CONV_NS / `SARCU_REF_PERIOD_NS)
`endif

// *** hw/sarcu_pkg.sv ***
// Types shared by the converter control logic
package sarcu_pkg;
	typedef enum logic [1:0] {
		SARCU_IDLE,
		SARCU_CONVERT
	} sarcu_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sarcu_sfr_req_t;

	typedef struct packed {
		logic start;
		logic [2:0] chan;
		logic power;
		logic ref_clk;
	} sarcu_core_ctl_t;
endpackage : sarcu_pkg

// *** hw/sarcu_refclk.sv ***
// Reference clock divider and gate for the converter
`timescale 1ns/10ps
`default_nettype none
module sarcu_refclk
	import sarcu_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Control
	input wire logic [2:0] prescale,
	input wire logic gate,
	// Output
	output logic tick
);
	typedef struct packed {
		logic [1:0] cnt;
		logic tick;
	} sarcu_div_t;

	sarcu_div_t st_reg;
	sarcu_div_t st_next;
	logic [1:0] top;

	always_comb begin
		case (prescale)
			3'h1: top = 2'h1;
			3'h2: top = 2'h3;
			default: top = 2'h0;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (!gate) begin // see [R10]
			st_next.cnt = 2'h0;
		end else if (st_reg.cnt >= top) begin // see [R9]
			st_next.cnt = 2'h0;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 2'h1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;

	gate_stops_a: assert property ( // see [R10]
		@(posedge clock) disable iff (!rstn)
		!gate |=> !tick) else $error("tick while gated");
	div4_spacing_a: assert property ( // see [R9]
		@(posedge clock) disable iff (!rstn)
		(tick && gate && prescale == 3'h2 && $stable(prescale))
		|=> !tick [*3]) else $error("divide by 4 spacing");
endmodule : sarcu_refclk
`default_nettype wire

// *** tb/sarcu_core_model.sv ***
// Behavioural model of the analog converter core
`timescale 1ns/10ps
`default_nettype none
module sarcu_core_model
	import sarcu_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Control from the unit
	input wire sarcu_core_ctl_t core_ctl,
	input wire logic [9:0] value,
	// Answer to the unit
	output logic core_sample_done,
	output logic [9:0] core_sample
);
	logic [1:0] wait_reg;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wait_reg <= 2'h0;
			core_sample_done <= 1'b0;
			core_sample <= 10'h000;
		end else if (!core_ctl.power) begin
			wait_reg <= 2'h0;
			core_sample_done <= 1'b0;
		end else if (core_ctl.start) begin
			wait_reg <= 2'h3;
			core_sample_done <= 1'b0;
		end else if (wait_reg != 2'h0) begin
			wait_reg <= wait_reg - 2'h1;
			if (wait_reg == 2'h1) begin
				core_sample_done <= 1'b1;
				core_sample <= value;
			end
		end
	end
endmodule : sarcu_core_model
`default_nettype wire

// *** tb/sarcu_top_tb.sv ***
// Self-checking bench for the converter control unit
`timescale 1ns/10ps
`default_nettype none
module sarcu_top_tb
	import sarcu_pkg::*;
;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} sarcu_row_t;
	localparam int CT = 4;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	sarcu_sfr_req_t sfr_req = '0;
	logic [7:0] sfr_rdata, gpio, aen;
	logic [7:0] sel_a = 8'h00;
	logic [7:0] sel_b = 8'h00;
	sarcu_core_ctl_t core_ctl;
	logic core_done, irq;
	logic [9:0] core_sample;
	logic [9:0] mval = 10'h000;
	int error_cnt = 0;
	int tests_run = 0;
	sarcu_row_t rows [6] = '{'{8'h94, 8'hFF, 8'h0F}, '{8'h94, 8'h05, 8'h05},
		'{8'h95, 8'hAA, 8'h00}, '{8'h96, 8'h55, 8'h00},
		'{8'h90, 8'h12, 8'h00}, '{8'h94, 8'h00, 8'h00}};
	logic [9:0] vals [3] = '{10'h3FF, 10'h000, 10'h2A5};
	int n, dv;
	always #12.5 clock = ~clock;
	sarcu_top #(.CONV_TICKS(CT)) dut (.clock(clock), .rstn(rstn),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.port1_function_select_a(sel_a), .port1_function_select_b(sel_b),
		.port1_gpio_mode(gpio), .port1_analog_enable(aen),
		.core_ctl(core_ctl), .core_sample_done(core_done),
		.core_sample(core_sample), .converter_irq(irq));
	sarcu_core_model core (.clock(clock), .rstn(rstn), .core_ctl(core_ctl),
		.value(mval), .core_sample_done(core_done), .core_sample(core_sample));
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		sfr_req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		sfr_req <= '0;
		@(posedge clock);
		#1 check({2'b00, sfr_rdata}, {2'b00, e});
	endtask : rd
	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++) rd(8'h94 + 8'(i), 8'h00);
		check({9'h000, irq}, 10'h000);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			sel_a <= 8'hA5 ^ 8'(i * 51);
			sel_b <= 8'h3C + 8'(i);
			@(posedge clock);
			#1 check({2'b00, gpio}, {2'b00, ~sel_a});
			check({2'b00, aen}, {2'b00, sel_a & sel_b});
		end
		for (int c = 0; c < 8; c++) begin
			wr(8'h97, {3'b000, 3'(c), 2'b00});
			#1 check({7'h00, core_ctl.chan}, 10'(c));
		end
		for (int c = 0; c < 3; c++) begin
			mval <= vals[c];
			dv = 1 << c;
			wr(8'h94, 8'h08 | 8'(c));
			wr(8'h97, {3'b011, 3'(c), 2'b10});
			n = 0;
			while (irq !== 1'b1 && n < 200) begin
				@(posedge clock);
				n++;
			end
			check(10'(n >= (CT - 1) * dv && n <= CT * dv + 12), 10'h001);
			rd(8'h95, vals[c][7:0]);
			rd(8'h96, {6'h00, vals[c][9:8]});
			rd(8'h97, {3'b111, 3'(c), 2'b01});
			wr(8'h97, {3'b011, 3'(c), 2'b00});
			#1 check({9'h000, irq}, 10'h000);
		end
		mval <= 10'h155;
		wr(8'h94, 8'h00);
		wr(8'h97, 8'h62);
		rd(8'h97, 8'h60);
		repeat (40) @(posedge clock);
		#1 check({9'h000, irq}, 10'h000);
		rd(8'h95, 8'hA5);
		wr(8'h97, 8'h40);
		wr(8'h94, 8'h08);
		wr(8'h97, 8'h22);
		repeat (30) @(posedge clock);
		#1 check({9'h000, irq}, 10'h000);
		rd(8'h97, 8'hA1);
		rd(8'h95, 8'h55);
		final_report();
	end
endmodule : sarcu_top_tb
`default_nettype wire
